// [src/shb_pkg.sv]
// shb_pkg: constants and types for the sensor subsystem glue block.
// assumes one 250 MHz clock ref_clk and synchronous active-low reset.
// Summary of operation
// - pins stay undriven during and just after resume-well reset.
// - local memory 640 KB, 32-bit words, twenty banks of 32 KB.
// - ecc corrects any single-bit error and detects double-bit errors.
// - each bank has a firmware-set power-gated low-power state.
// - type 0 configuration cycles from host go to configuration space.
// - first memory window reaches driver-owned functional registers.
// - second memory window aliases configuration space, only when hidden.
// - dma produces memory addresses up to 64 bits wide.
// - host interrupts use legacy irq lines only, never message interrupts.
// - no wake events generated; capability reported absent.
// - operation only in working and low-power-idle states.
// - messages with interrupt flow hub-host, host-hub, hub-sec, sec-hub.
// - status and remap registers read/write by both sides, no interrupt.
// - the local interrupt controller accepts ioapic interrupt messages.
// - the security engine also reaches local memory as shared memory.
`default_nettype none
package shb_pkg;
	localparam int unsigned shb_banks = 20;
	localparam int unsigned shb_bank_words = 8192;
	localparam int unsigned shb_addr_w = 18;
	localparam int unsigned shb_bank_w = 5;
	localparam int unsigned shb_word_w = 13;
	localparam int unsigned shb_data_w = 32;
	localparam int unsigned shb_code_w = 39;
	localparam int unsigned shb_dma_w = 64;
	localparam int unsigned shb_wake_ns = 40;
	localparam int unsigned shb_clk_mhz = 250;
	localparam logic [3:0] shb_wake_cycles = 4'((shb_wake_ns * shb_clk_mhz + 999) / 1000);
	localparam int unsigned shb_cfg_w = 10;
	localparam logic [1:0] shb_win_cfg = 2'h0;
	localparam logic [1:0] shb_win_func = 2'h1;
	localparam logic [1:0] shb_win_alias = 2'h2;
	localparam logic [1:0] shb_win_none = 2'h3;
	localparam logic [1:0] shb_flow_hub_host = 2'h0;
	localparam logic [1:0] shb_flow_host_hub = 2'h1;
	localparam logic [1:0] shb_flow_hub_sec = 2'h2;
	localparam logic [1:0] shb_flow_sec_hub = 2'h3;
	localparam logic [31:0] shb_reg_reset = 32'h0000_0000;
	localparam logic shb_wake_capable = 1'b0;
	typedef enum logic [1:0] {
		shb_idle = 2'b00,
		shb_wake = 2'b01,
		shb_read = 2'b10,
		shb_done = 2'b11
	} shb_mem_state_t;
endpackage : shb_pkg
`default_nettype wire

// [src/shb_ecc.sv]
// shb_ecc: hamming plus overall parity secded for 32-bit words.
// assumes purely combinational use by the memory controller.
`default_nettype none
module shb_ecc (
	input wire logic [31:0] wr_data,
	output logic [38:0] wr_code,
	input wire logic [38:0] rd_code,
	output logic [31:0] rd_data,
	output logic single_err,
	output logic multi_err
);
	function automatic logic [37:0] spread(input logic [31:0] d);
		logic [37:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p-1] = d[k];
				k++;
			end
		end
		return c;
	endfunction

	function automatic logic [5:0] syn(input logic [37:0] c);
		logic [5:0] s;
		s = '0;
		for (int p = 1; p < 39; p++) begin
			if (c[p-1]) s = s ^ 6'(p);
		end
		return s;
	endfunction

	logic [37:0] wc;
	logic [37:0] rc;
	logic [37:0] fixed;
	logic [5:0] s;
	logic par;

	always_comb begin
		wc = spread(wr_data);
		s = syn(wc);
		for (int i = 0; i < 6; i++) wc[(1 << i) - 1] = s[i];
		wr_code = {^wc, wc};
		rc = rd_code[37:0];
		s = syn(rc);
		par = ^rd_code;
		fixed = rc;
		if (s != 6'h00 && par && s < 6'd39) fixed[s-6'd1] = ~fixed[s-6'd1];
		single_err = par;
		multi_err = (s != 6'h00) && !par;
		rd_data = '0;
		for (int p = 1, k = 0; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				rd_data[k] = fixed[p-1];
				k++;
			end
		end
	end
endmodule // shb_ecc
`default_nettype wire

// [src/shb_hub.sv]
// shb_hub: banked ecc memory, host bridge decode, messaging and irq glue.
// assumes requesters hold a request until its ack; inputs synchronous to ref_clk.
`default_nettype none
module shb_hub (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic resume_well_reset_n,
	input wire logic mcu_req,
	input wire logic mcu_we,
	input wire logic [17:0] mcu_addr,
	input wire logic [31:0] mcu_wdata,
	input wire logic sec_req,
	input wire logic sec_we,
	input wire logic [17:0] sec_addr,
	input wire logic [31:0] sec_wdata,
	output logic mcu_ack,
	output logic sec_ack,
	output logic [31:0] mem_rdata,
	input wire logic [19:0] bank_gate,
	output logic [19:0] bank_active,
	output logic ecc_corr_flag,
	output logic ecc_corr_event,
	output logic ecc_uncorr_flag,
	input wire logic ecc_flag_clear,
	input wire logic host_req,
	input wire logic host_cfg_type0,
	input wire logic host_we,
	input wire logic [31:0] host_addr,
	input wire logic [31:0] host_wdata,
	input wire logic [31:0] func_window_base,
	input wire logic [31:0] alias_window_base,
	input wire logic [31:0] window_size_mask,
	input wire logic cfg_hidden,
	output logic [1:0] host_target,
	output logic host_hit,
	output logic cfg_we,
	output logic [9:0] cfg_index,
	output logic func_we,
	output logic [31:0] func_index,
	output logic [31:0] host_fwd_data,
	input wire logic [31:0] dma_addr_hi,
	input wire logic [31:0] dma_addr_lo,
	output logic [63:0] dma_mem_addr,
	input wire logic host_irq_src,
	output logic legacy_irq_line,
	output logic msi_enable,
	output logic wake_event_signal,
	output logic wake_capable,
	input wire logic sys_working,
	input wire logic msg_send,
	input wire logic [1:0] msg_flow,
	input wire logic [31:0] msg_data,
	output logic [31:0] msg_payload,
	output logic msg_to_host_irq,
	output logic msg_to_hub_irq,
	output logic msg_to_sec_irq,
	input wire logic [3:0] msg_irq_ack,
	input wire logic scratch_we,
	input wire logic scratch_sel,
	input wire logic [31:0] scratch_wdata,
	output logic [31:0] status_reg,
	output logic [31:0] remap_reg,
	input wire logic ioapic_msg_valid,
	input wire logic [7:0] ioapic_vector,
	output logic lapic_irq,
	output logic [7:0] lapic_vector,
	input wire logic lapic_eoi,
	output logic [7:0] gpio_oe_n,
	output logic [7:0] gpio_out
);
	typedef struct packed {
		shb_pkg::shb_mem_state_t st;
		logic [3:0] wait_cnt;
		logic grant_sec;
		logic we;
		logic [17:0] addr;
		logic [31:0] wdata;
		logic [19:0] active;
		logic [31:0] rdata;
		logic corr;
		logic corr_ev;
		logic uncorr;
		logic mcu_ack;
		logic sec_ack;
		logic [1:0] target;
		logic hit;
		logic cfg_we;
		logic [9:0] cfg_index;
		logic func_we;
		logic [31:0] func_index;
		logic [31:0] fwd;
		logic [63:0] dma;
		logic irq;
		logic [31:0] payload;
		logic [3:0] msg_irq;
		logic [31:0] status;
		logic [31:0] remap;
		logic lirq;
		logic [7:0] lvec;
	} shb_state_t;

	shb_state_t r;
	shb_state_t next_r;
	// storage array; each word carries its secded code
	logic [38:0] mem [0:(shb_pkg::shb_banks*shb_pkg::shb_bank_words)-1];
	logic [38:0] wr_code;
	logic [38:0] rd_word;
	logic [31:0] fix_data;
	logic single_err;
	logic multi_err;
	logic [4:0] bank;
	logic in_range;
	logic mem_wr;
	logic [17:0] mem_addr;
	logic busy;
	logic take_mcu;
	logic take_sec;
	logic [31:0] win_page;
	logic func_hit;
	logic alias_hit;
	wire logic [19:0] gate_now;

	shb_ecc u_ecc (
		.wr_data(r.wdata),
		.wr_code(wr_code),
		.rd_code(rd_word),
		.rd_data(fix_data),
		.single_err(single_err),
		.multi_err(multi_err)
	);

	assign bank = r.addr[17:13];
	assign in_range = bank < 5'(shb_pkg::shb_banks);
	assign mem_addr = {bank, r.addr[12:0]};
	assign busy = r.st != shb_pkg::shb_idle;
	// a standing ack means its request is still up; never take it twice
	assign take_mcu = mcu_req && !r.mcu_ack;
	assign take_sec = sec_req && !r.sec_ack;
	assign win_page = host_addr & ~window_size_mask;
	assign func_hit = win_page == func_window_base;
	assign alias_hit = cfg_hidden && win_page == alias_window_base;

	// firmware gating waits while a transfer still uses that bank
	for (genvar g = 0; g < shb_pkg::shb_banks; g++) begin : g_gate
		assign gate_now[g] = bank_gate[g] && !(busy && bank == 5'(g));
	end

	always_comb begin
		next_r = r;
		next_r.mcu_ack = 1'b0;
		next_r.sec_ack = 1'b0;
		next_r.corr_ev = 1'b0;
		next_r.cfg_we = 1'b0;
		next_r.func_we = 1'b0;
		next_r.hit = 1'b0;
		mem_wr = 1'b0;
		next_r.active = r.active & ~gate_now;
		case (r.st)
			shb_pkg::shb_idle: begin
				// microcontroller first, security engine shares the same port
				if (take_mcu || take_sec) begin
					next_r.grant_sec = !take_mcu;
					next_r.we = take_mcu ? mcu_we : sec_we;
					next_r.addr = take_mcu ? mcu_addr : sec_addr;
					next_r.wdata = take_mcu ? mcu_wdata : sec_wdata;
					next_r.wait_cnt = shb_pkg::shb_wake_cycles;
					next_r.st = shb_pkg::shb_wake;
				end
			end
			shb_pkg::shb_wake: begin
				if (!in_range) begin
					next_r.rdata = '0;
					next_r.st = shb_pkg::shb_done;
				end else if (!r.active[bank]) begin
					// gated bank: count out its wake time, then restore
					if (r.wait_cnt == 4'h0) next_r.active[bank] = 1'b1;
					else next_r.wait_cnt = r.wait_cnt - 4'h1;
				end else if (r.we) begin
					mem_wr = 1'b1;
					next_r.st = shb_pkg::shb_done;
				end else begin
					next_r.st = shb_pkg::shb_read;
				end
			end
			shb_pkg::shb_read: begin
				next_r.rdata = fix_data;
				if (single_err) begin
					next_r.corr = 1'b1;
					next_r.corr_ev = 1'b1;
				end
				if (multi_err) next_r.uncorr = 1'b1;
				next_r.st = shb_pkg::shb_done;
			end
			shb_pkg::shb_done: begin
				next_r.mcu_ack = !r.grant_sec;
				next_r.sec_ack = r.grant_sec;
				next_r.st = shb_pkg::shb_idle;
			end
			default: next_r.st = shb_pkg::shb_idle;
		endcase

		// clear loses to a same-cycle set
		if (ecc_flag_clear) begin
			next_r.corr = next_r.corr_ev;
			next_r.uncorr = (r.st == shb_pkg::shb_read) && multi_err;
		end

		// host bridge decode
		next_r.target = shb_pkg::shb_win_none;
		if (host_req) begin
			if (host_cfg_type0) begin
				next_r.target = shb_pkg::shb_win_cfg;
				next_r.cfg_index = host_addr[11:2];
				next_r.cfg_we = host_we;
				next_r.hit = 1'b1;
			end else if (func_hit) begin
				next_r.target = shb_pkg::shb_win_func;
				next_r.func_index = host_addr & window_size_mask;
				next_r.func_we = host_we;
				next_r.hit = 1'b1;
			end else if (alias_hit) begin
				next_r.target = shb_pkg::shb_win_alias;
				next_r.cfg_index = host_addr[11:2];
				next_r.cfg_we = host_we;
				next_r.hit = 1'b1;
			end
			next_r.fwd = host_wdata;
		end

		next_r.dma = {dma_addr_hi, dma_addr_lo};
		next_r.irq = host_irq_src && sys_working;

		// messaging: payload plus interrupt per flow; ack clears unless resent
		for (int i = 0; i < 4; i++) begin
			if (msg_irq_ack[i]) next_r.msg_irq[i] = 1'b0;
		end
		if (msg_send && sys_working) begin
			next_r.payload = msg_data;
			next_r.msg_irq[msg_flow] = 1'b1;
		end

		// dual-access scratch registers; writes never touch interrupts
		if (scratch_we) begin
			if (scratch_sel) next_r.remap = scratch_wdata;
			else next_r.status = scratch_wdata;
		end

		// local interrupt controller takes ioapic messages; eoi clears
		if (lapic_eoi) next_r.lirq = 1'b0;
		if (ioapic_msg_valid) begin
			next_r.lirq = 1'b1;
			next_r.lvec = ioapic_vector;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn || !resume_well_reset_n) begin
			r <= '0;
			r.st <= shb_pkg::shb_idle;
			r.active <= '1;
			r.target <= shb_pkg::shb_win_none;
			r.status <= shb_pkg::shb_reg_reset;
			r.remap <= shb_pkg::shb_reg_reset;
		end else begin
			r <= next_r;
		end
	end

	// no reset on the array itself; ecc only valid after first write
	always_ff @(posedge ref_clk) begin
		if (mem_wr) mem[mem_addr] <= wr_code;
	end
	assign rd_word = mem[mem_addr];

	assign mcu_ack = r.mcu_ack;
	assign sec_ack = r.sec_ack;
	assign mem_rdata = r.rdata;
	assign bank_active = r.active;
	assign ecc_corr_flag = r.corr;
	assign ecc_corr_event = r.corr_ev;
	assign ecc_uncorr_flag = r.uncorr;
	assign host_target = r.target;
	assign host_hit = r.hit;
	assign cfg_we = r.cfg_we;
	assign cfg_index = r.cfg_index;
	assign func_we = r.func_we;
	assign func_index = r.func_index;
	assign host_fwd_data = r.fwd;
	assign dma_mem_addr = r.dma;
	assign legacy_irq_line = r.irq;
	assign msi_enable = 1'b0;
	assign wake_event_signal = 1'b0;
	assign wake_capable = shb_pkg::shb_wake_capable;
	assign msg_payload = r.payload;
	assign msg_to_host_irq = r.msg_irq[shb_pkg::shb_flow_hub_host];
	assign msg_to_hub_irq = r.msg_irq[shb_pkg::shb_flow_host_hub]
		| r.msg_irq[shb_pkg::shb_flow_sec_hub];
	assign msg_to_sec_irq = r.msg_irq[shb_pkg::shb_flow_hub_sec];
	assign status_reg = r.status;
	assign remap_reg = r.remap;
	assign lapic_irq = r.lirq;
	assign lapic_vector = r.lvec;
	// pins released (undriven) through reset; peripherals not in this block
	assign gpio_oe_n = 8'hFF;
	assign gpio_out = 8'h00;
endmodule // shb_hub
`default_nettype wire

// [dv/shb_hub_checker.sv]
// shb_hub_checker: port assertions for shb_hub.
// assumes bind onto shb_hub; ecc faults cannot be injected at the ports.
`default_nettype none
module shb_hub_checker (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic resume_well_reset_n,
	input wire logic host_irq_src,
	input wire logic sys_working,
	input wire logic legacy_irq_line,
	input wire logic msi_enable,
	input wire logic wake_event_signal,
	input wire logic wake_capable,
	input wire logic [31:0] dma_addr_hi,
	input wire logic [31:0] dma_addr_lo,
	input wire logic [63:0] dma_mem_addr,
	input wire logic host_req,
	input wire logic host_cfg_type0,
	input wire logic [31:0] host_addr,
	input wire logic host_hit,
	input wire logic [1:0] host_target,
	input wire logic [9:0] cfg_index,
	input wire logic cfg_hidden,
	input wire logic msg_send,
	input wire logic [1:0] msg_flow,
	input wire logic msg_to_host_irq,
	input wire logic ioapic_msg_valid,
	input wire logic [7:0] ioapic_vector,
	input wire logic lapic_irq,
	input wire logic [7:0] lapic_vector,
	input wire logic [7:0] gpio_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic ok = resetn & resume_well_reset_n;
	wire logic [9:0] idx = host_addr[11:2];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!ok);
	sequence s_send;
		msg_send && sys_working && msg_flow == shb_pkg::shb_flow_hub_host;
	endsequence
	sequence s_ring;
		msg_to_host_irq;
	endsequence
	property p_pins;
		gpio_oe_n == 8'hff;
	endproperty
	property p_irq;
		$past(ok) |-> legacy_irq_line == ($past(host_irq_src) && $past(sys_working));
	endproperty
	property p_msi;
		!msi_enable;
	endproperty
	property p_wake;
		!wake_event_signal && !wake_capable;
	endproperty
	property p_dma;
		$past(ok) |-> dma_mem_addr == {$past(dma_addr_hi), $past(dma_addr_lo)};
	endproperty
	property p_cfg;
		host_req && host_cfg_type0 |=> host_hit && host_target == shb_pkg::shb_win_cfg
			&& cfg_index == $past(idx);
	endproperty
	property p_alias;
		host_hit && host_target == shb_pkg::shb_win_alias |-> $past(cfg_hidden);
	endproperty
	property p_msg;
		s_send |=> s_ring;
	endproperty
	property p_lapic;
		ioapic_msg_valid |=> lapic_irq && lapic_vector == $past(ioapic_vector);
	endproperty
	a_pins: assert property (p_pins) else $error("pins driven");
	a_irq: assert property (p_irq) else $error("irq line wrong");
	a_msi: assert property (p_msi) else $error("msi enabled");
	a_wake: assert property (p_wake) else $error("wake seen");
	a_dma: assert property (p_dma) else $error("dma addr wrong");
	a_cfg: assert property (p_cfg) else $error("type0 not routed");
	a_alias: assert property (p_alias) else $error("alias while visible");
	a_msg: assert property (p_msg) else $error("host irq missing");
	a_lapic: assert property (p_lapic) else $error("lapic missed");
endmodule // shb_hub_checker
`default_nettype wire

// [dv/shb_sec_model.sv]
// shb_sec_model: security engine doing one word access per go.
// assumes go is changed by nonblocking assignment at the falling edge.
`default_nettype none
module shb_sec_model (
	input wire logic clk,
	input wire logic go,
	input wire logic we,
	input wire logic [17:0] addr,
	input wire logic [31:0] wdata,
	input wire logic sec_ack,
	input wire logic [31:0] mem_rdata,
	output logic sec_req = 1'b0,
	output logic sec_we = 1'b0,
	output logic [17:0] sec_addr = '0,
	output logic [31:0] sec_wdata = '0,
	output logic done = 1'b0,
	output logic [31:0] rdata = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk) begin
		done <= sec_req && sec_ack;
		if (sec_req && sec_ack) rdata <= mem_rdata;
	end
	always @(negedge clk) begin
		if (done) begin
			sec_req <= 1'b0;
			sec_we <= 1'b0;
			// released lines must not keep the last value
			sec_addr <= ~sec_addr;
			sec_wdata <= ~sec_wdata;
		end else if (go && !sec_req) begin
			sec_req <= 1'b1;
			sec_we <= we;
			sec_addr <= addr;
			sec_wdata <= wdata;
		end
	end
endmodule // shb_sec_model
`default_nettype wire

// [dv/shb_hub_tb.sv]
// shb_hub_tb: directed tests of shb_hub with a security engine model.
// assumes the checker is bound below; inputs move at the falling edge.
`default_nettype none
module shb_hub_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, resetn = 0, resume_well_reset_n = 1, mcu_req = 0, mcu_we = 0;
	logic sec_req, sec_we, mcu_ack, sec_ack, host_hit, cfg_we, func_we, legacy_irq_line;
	logic [17:0] mcu_addr = 0, sec_addr, addr = 0;
	logic [31:0] mcu_wdata = 0, sec_wdata, mem_rdata, wdata = 0, rdata;
	logic [19:0] bank_gate = 0, bank_active;
	logic ecc_corr_flag, ecc_corr_event, ecc_uncorr_flag, ecc_flag_clear = 0;
	logic host_req = 0, host_cfg_type0 = 0, host_we = 0, cfg_hidden = 0, go = 0, we = 0;
	logic [31:0] host_addr = 0, host_wdata = 0, func_window_base = 32'h1000_0000;
	logic [31:0] alias_window_base = 32'h2000_0000, window_size_mask = 32'h0000_0fff;
	logic [1:0] host_target, msg_flow = 0;
	logic msi_enable, wake_event_signal, wake_capable, done;
	logic [9:0] cfg_index;
	logic [31:0] func_index, host_fwd_data, dma_addr_hi = 0, dma_addr_lo = 0, msg_data = 0;
	logic [63:0] dma_mem_addr;
	logic host_irq_src = 0, sys_working = 1, msg_send = 0, scratch_we = 0, scratch_sel = 0;
	logic [31:0] msg_payload, scratch_wdata = 0, status_reg, remap_reg;
	logic msg_to_host_irq, msg_to_hub_irq, msg_to_sec_irq, ioapic_msg_valid = 0;
	logic lapic_irq, lapic_eoi = 0;
	logic [3:0] msg_irq_ack = 0;
	logic [7:0] ioapic_vector = 0, lapic_vector, gpio_oe_n, gpio_out;
	int bad_count = 0, checks = 0, cyc = 0;
	shb_hub dut (.*);
	shb_sec_model sec_i (.clk(ref_clk), .go(go), .we(we), .addr(addr), .wdata(wdata),
		.sec_ack(sec_ack), .mem_rdata(mem_rdata), .sec_req(sec_req), .sec_we(sec_we),
		.sec_addr(sec_addr), .sec_wdata(sec_wdata), .done(done), .rdata(rdata));
	always #2 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		// run needs well under a thousand cycles
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic mem(input logic w, input logic [17:0] a, input logic [31:0] d,
		output logic [31:0] q, output int n);
		n = 0;
		@(negedge ref_clk);
		mcu_req = 1;
		mcu_we = w;
		mcu_addr = a;
		mcu_wdata = d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (mcu_ack !== 1'b1 && n < 40);
		q = mem_rdata;
		chk("mcu ack", 1, mcu_ack);
		@(negedge ref_clk);
		mcu_req = 0;
		mcu_addr = ~a;
	endtask
	task automatic sec(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n = 0;
		@(negedge ref_clk);
		go <= 1;
		we <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(negedge ref_clk);
			n++;
		end while (done !== 1'b1 && n < 40);
		go <= 0;
		chk("sec done", 1, done);
	endtask
	task automatic host(input logic t0, input logic [31:0] a, input logic [1:0] tgt);
		logic [31:0] d;
		logic cp;
		d = ~a;
		cp = tgt == shb_pkg::shb_win_cfg || tgt == shb_pkg::shb_win_alias;
		@(negedge ref_clk);
		host_req = 1;
		host_cfg_type0 = t0;
		host_we = a[4];
		host_addr = a;
		host_wdata = d;
		@(negedge ref_clk);
		host_req = 0;
		chk("host target", tgt, host_target);
		chk("host hit", tgt != shb_pkg::shb_win_none, host_hit);
		chk("cfg we", a[4] && cp, cfg_we);
		chk("func we", a[4] && tgt == shb_pkg::shb_win_func, func_we);
		chk("fwd data", d, host_fwd_data);
		if (cp) chk("cfg index", a[11:2], cfg_index);
		if (tgt == shb_pkg::shb_win_func) chk("func index", a & 32'h0000_0fff, func_index);
	endtask
	task automatic t_mem();
		logic [31:0] q;
		int na, ng;
		mem(1, {5'h13, 13'h1fff}, 32'hcafe_0013, q, na);
		mem(0, {5'h13, 13'h1fff}, '0, q, na);
		chk("top word", 32'hcafe_0013, q);
		mem(0, {5'h14, 13'h0000}, '0, q, na);
		chk("past end", 0, q);
		mem(1, 18'h0_6000, 32'h5a5a_0003, q, na);
		bank_gate = 20'h0_0008;
		repeat (3) @(negedge ref_clk);
		chk("bank gated", 0, bank_active[3]);
		mem(1, 18'h0_6000, 32'ha5a5_0003, q, ng);
		bank_gate = 0;
		chk("gated wait", 1, ng >= na + 10);
		mem(0, 18'h0_6000, '0, q, na);
		chk("restored word", 32'ha5a5_0003, q);
		chk("no ecc flags", 0, {ecc_corr_flag, ecc_corr_event, ecc_uncorr_flag});
		ecc_flag_clear = 1;
		sec(1, 18'h0_a004, 32'h0bad_f00d);
		ecc_flag_clear = 0;
		sec(0, 18'h0_a004, '0);
		chk("sec word", 32'h0bad_f00d, rdata);
		mem(0, 18'h0_a004, '0, q, na);
		chk("shared word", 32'h0bad_f00d, q);
		$display("memory tests done");
	endtask
	task automatic t_misc();
		logic [2:0] exp [4] = '{3'b100, 3'b010, 3'b001, 3'b010};
		host(1, 32'h0000_0abc, shb_pkg::shb_win_cfg);
		host(0, 32'h1000_0134, shb_pkg::shb_win_func);
		host(0, 32'h2000_0010, shb_pkg::shb_win_none);
		cfg_hidden = 1;
		host(0, 32'h2000_0010, shb_pkg::shb_win_alias);
		cfg_hidden = 0;
		dma_addr_hi = 32'hfedc_ba98;
		dma_addr_lo = 32'h7654_3210;
		host_irq_src = 1;
		@(negedge ref_clk);
		chk("dma addr", 64'hfedc_ba98_7654_3210, dma_mem_addr);
		chk("irq line", 1, legacy_irq_line);
		chk("no msi wake", 0, {msi_enable, wake_event_signal, wake_capable});
		sys_working = 0;
		@(negedge ref_clk);
		chk("irq idle", 0, legacy_irq_line);
		sys_working = 1;
		host_irq_src = 0;
		for (int f = 0; f < 4; f++) begin
			@(negedge ref_clk);
			msg_send = 1;
			msg_flow = f[1:0];
			msg_data = 32'h00c0_0000 | f;
			@(negedge ref_clk);
			msg_send = 0;
			chk("msg irq", exp[f], {msg_to_host_irq, msg_to_hub_irq, msg_to_sec_irq});
			chk("payload", 32'h00c0_0000 | f, msg_payload);
			msg_irq_ack = 4'h1 << f;
			@(negedge ref_clk);
			msg_irq_ack = 0;
			chk("irq cleared", 0, {msg_to_host_irq, msg_to_hub_irq, msg_to_sec_irq});
		end
		$display("host and msg tests done");
	endtask
	task automatic t_regs();
		scratch_we = 1;
		scratch_wdata = 32'h1111_aaaa;
		@(negedge ref_clk);
		scratch_sel = 1;
		scratch_wdata = 32'h2222_bbbb;
		@(negedge ref_clk);
		scratch_we = 0;
		chk("status", 32'h1111_aaaa, status_reg);
		chk("remap", 32'h2222_bbbb, remap_reg);
		chk("no irq", 0, {msg_to_host_irq, msg_to_hub_irq, msg_to_sec_irq, lapic_irq});
		ioapic_msg_valid = 1;
		ioapic_vector = 8'h5c;
		@(negedge ref_clk);
		ioapic_msg_valid = 0;
		chk("lapic", 9'h15c, {lapic_irq, lapic_vector});
		lapic_eoi = 1;
		@(negedge ref_clk);
		lapic_eoi = 0;
		chk("eoi", 0, lapic_irq);
		resume_well_reset_n = 0;
		@(negedge ref_clk);
		resume_well_reset_n = 1;
		chk("pins in reset", 16'hff00, {gpio_oe_n, gpio_out});
		chk("banks on", 20'hf_ffff, bank_active);
		chk("regs reset", 0, {status_reg, remap_reg});
		$display("register tests done");
	endtask
	initial begin
		// every request starts low while resetn holds the block off
		repeat (12) @(negedge ref_clk);
		chk("pins after reset", 16'hff00, {gpio_oe_n, gpio_out});
		resetn = 1;
		t_mem();
		t_misc();
		t_regs();
		give_verdict();
	end
endmodule // shb_hub_tb
bind shb_hub shb_hub_checker chk_i (.*);
`default_nettype wire
